/* common/flash_ctl_pkg.sv */
// Constants and types for the program flash controller.
// Assumes one 200 MHz clock shared by processor, engine and SFR port.
package flash_ctl_pkg;

  // Special function register addresses
  localparam logic [7:0] SFR_ERASE_PATTERN = 8'h94;
  localparam logic [7:0] SFR_FLASH_CTRL    = 8'hB2;
  localparam logic [7:0] SFR_PAGE_ADDR     = 8'hB7;
  localparam logic [7:0] SFR_IRQ_REQUEST   = 8'hC0;

  // Bit positions in the flash control register
  localparam int PWE_BIT      = 0;
  localparam int MEEN_BIT     = 1;
  localparam int STATUS_A_BIT = 5;
  localparam int SECURITY_ENABLE_BIT   = 6;

  // Bit positions in the interrupt request register
  localparam int IDLE_IRQ_BIT = 2;
  localparam int DROP_IRQ_BIT = 3;
  localparam int SKIP_IRQ_BIT = 4;

  // Page number field of the page address register
  localparam int PAGE_LSB = 2;
  localparam int PAGE_MSB = 7;

  // Erase patterns and flash contents
  localparam logic [7:0] PATTERN_MASS = 8'hAA;
  localparam logic [7:0] PATTERN_PAGE = 8'h55;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // Array geometry
  localparam int FLASH_AW       = 18;
  localparam int PAGE_BYTES     = 1024;
  localparam int PAGE_SHIFT     = 10;
  localparam int ENGINE_WORDS   = 4096;
  localparam int WINDOW_SHIFT   = 15;
  localparam logic [2:0] RESET_BANK = 3'h0;

  // Timing
  localparam int STATUS_A_CYCLES = 60;
  localparam int CLK_MHZ        = 200;
  localparam int BYTE_WRITE_US  = 42;
  localparam int PAGE_ERASE_MS  = 20;
  localparam int BYTE_WRITE_CYCLES = BYTE_WRITE_US * CLK_MHZ;
  localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0]
  {
    OP_IDLE  = 2'b00,
    OP_WRITE = 2'b01,
    OP_PAGE  = 2'b10,
    OP_MASS  = 2'b11
  } flash_op_t;

endpackage

/* logic/flash_timer.sv */
// Down counter timing one flash operation.
// Start and count come from the same clock domain.
module flash_timer
  import flash_ctl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [31:0] count,
  output logic             busy,
  output logic             done
);

  logic [31:0] remaining;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      remaining <= 32'h0000_0000;
      done      <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
        remaining <= count;
      else if (remaining != 32'h0000_0000)
      begin
        remaining <= remaining - 32'h0000_0001;
        done      <= (remaining == 32'h0000_0001);
      end
    end
  end

  assign busy = (remaining != 32'h0000_0000);

endmodule

/* logic/flash_write_erase_bank_security.sv */
// Program flash write, erase, bank mapping and security control.
// Assumes processor, engine, SFR port and array on mclk; ICE enable is a pin.
module flash_write_erase_bank_security
  import flash_ctl_pkg::*;
#(
  parameter int WRITE_CYCLES = BYTE_WRITE_CYCLES,
  parameter int ERASE_CYCLES = PAGE_ERASE_CYCLES
)
(
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          sfrAddr,
  input  wire logic [7:0]          sfrWrData,
  input  wire logic                sfrWr,
  input  wire logic                sfrRd,
  output logic [7:0]               sfrRdData,
  input  wire logic                irqGlobalEnable,
  input  wire logic                bankSelWr,
  input  wire logic [2:0]          bankSelData,
  output logic [2:0]               upperBankSelect,
  input  wire logic [7:0]          engineCodeLocation,
  input  wire logic [11:0]         engineFetchWord,
  output logic [FLASH_AW-1:0]      engineFetchAddr,
  input  wire logic [15:0]         progAddr,
  output logic [FLASH_AW-1:0]      progFlashAddr,
  input  wire logic [7:0]          flashRdData,
  output logic [7:0]               progRdData,
  input  wire logic                xStore,
  input  wire logic [15:0]         xAddr,
  input  wire logic [7:0]          xData,
  output logic                     xramWr,
  output logic [15:0]              xramAddr,
  output logic [7:0]               xramData,
  input  wire logic                engineBusy,
  input  wire logic                enginePassDue,
  output logic                     enginePassSkip,
  output logic                     engineIdleIrq,
  output logic                     writeCollisionDropIrq,
  output logic                     writeCollisionSkipIrq,
  input  wire logic                iceEnable,
  output logic                     iceGrant,
  input  wire logic                iceMassErase,
  input  wire logic                icePageErase,
  input  wire logic [5:0]          icePage,
  input  wire logic                iceWrite,
  input  wire logic [FLASH_AW-1:0] iceAddr,
  input  wire logic [7:0]          iceData,
  output logic                     flashWr,
  output logic                     flashPageErase,
  output logic                     flashMassErase,
  output logic [FLASH_AW-1:0]      flashAddr,
  output logic [7:0]               flashWrData,
  output logic                     flashBusy,
  output logic                     statusA
);

  flash_op_t   op;
  logic        writeEnable;
  logic        massEraseEnable;
  logic [5:0]  erasePageNumber;
  logic        securityEnable;
  logic        idleFlag;
  logic        dropFlag;
  logic        skipFlag;
  logic [5:0]  prebootCount;
  logic        iceMeta;
  logic        iceSync;
  logic        engineBusyLast;
  logic        timerStart;
  logic [31:0] timerCount;
  logic        timerDone;
  logic        timerBusy;
  logic [5:0]  erasingPage;

  logic              patternWr;
  logic              ctrlWr;
  logic              irqRegWr;
  logic              cpuFlashWr;
  logic              cpuPage0;
  logic              icePage0;
  logic              idleEvt;
  logic              dropEvt;
  logic              skipEvt;
  logic              reqMass;
  logic              reqPage;
  logic              reqWrite;
  logic [5:0]        reqPageNum;
  logic [FLASH_AW-1:0] reqAddr;
  logic [7:0]        reqData;
  logic [FLASH_AW-1:0] cpuFlashAddr;

  // Fixed lower window, banked upper window
  function automatic logic [FLASH_AW-1:0] mapAddr(input logic [15:0] a,
                                                  input logic [2:0]  bank);
    logic [2:0] sel;
    sel = a[WINDOW_SHIFT] ? bank : 3'h0;
    return {sel, a[WINDOW_SHIFT-1:0]};
  endfunction

  assign patternWr = sfrWr && (sfrAddr == SFR_ERASE_PATTERN);
  assign ctrlWr    = sfrWr && (sfrAddr == SFR_FLASH_CTRL);
  assign irqRegWr  = sfrWr && (sfrAddr == SFR_IRQ_REQUEST);

  assign cpuFlashWr   = xStore && writeEnable;
  assign cpuFlashAddr = mapAddr(xAddr, upperBankSelect);
  assign cpuPage0     = (cpuFlashAddr[FLASH_AW-1:PAGE_SHIFT] == '0);
  assign icePage0     = (icePage == 6'h00);

  // Emulator pin synchroniser
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      iceMeta <= 1'b0;
      iceSync <= 1'b0;
    end
    else
    begin
      iceMeta <= iceEnable;
      iceSync <= iceMeta;
    end
  end

  // Pre-boot window
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      prebootCount <= 6'd0;
    else if (prebootCount != 6'(STATUS_A_CYCLES))
      prebootCount <= prebootCount + 6'd1;
  end

  assign statusA  = (prebootCount != 6'(STATUS_A_CYCLES));
  assign iceGrant = iceSync && !statusA && !securityEnable;

  // Request selection; firmware ahead of emulator
  always_comb
  begin
    reqMass    = 1'b0;
    reqPage    = 1'b0;
    reqWrite   = 1'b0;
    reqPageNum = erasePageNumber;
    reqAddr    = cpuFlashAddr;
    reqData    = xData;
    dropEvt    = 1'b0;
    if (patternWr && sfrWrData == PATTERN_MASS)
      reqMass = massEraseEnable && iceSync;
    else if (patternWr && sfrWrData == PATTERN_PAGE)
      reqPage = !(securityEnable && erasePageNumber == 6'h00);
    else if (cpuFlashWr)
    begin
      if (engineBusy)
        dropEvt = 1'b1;
      else
        reqWrite = !(securityEnable && cpuPage0);
    end
    else if (iceMassErase && iceSync && !statusA)
      reqMass = 1'b1;
    else if (icePageErase && iceGrant && !(securityEnable && icePage0))
    begin
      reqPage    = 1'b1;
      reqPageNum = icePage;
    end
    else if (iceWrite && iceGrant)
    begin
      if (engineBusy)
        dropEvt = 1'b1;
      else
      begin
        reqWrite = 1'b1;
        reqAddr  = iceAddr;
        reqData  = iceData;
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      op             <= OP_IDLE;
      flashWr        <= 1'b0;
      flashPageErase <= 1'b0;
      flashMassErase <= 1'b0;
      flashAddr      <= '0;
      flashWrData    <= ERASED_BYTE;
      erasingPage    <= 6'h00;
      timerStart     <= 1'b0;
      timerCount     <= 32'h0000_0000;
    end
    else
    begin
      flashWr        <= 1'b0;
      flashPageErase <= 1'b0;
      flashMassErase <= 1'b0;
      timerStart     <= 1'b0;
      case (op)
        OP_IDLE:
        begin
          if (reqMass)
          begin
            op             <= OP_MASS;
            flashMassErase <= 1'b1;
            timerStart     <= 1'b1;
            timerCount     <= 32'(ERASE_CYCLES);
          end
          else if (reqPage)
          begin
            op             <= OP_PAGE;
            flashPageErase <= 1'b1;
            flashAddr      <= FLASH_AW'({reqPageNum, 10'h000});
            erasingPage    <= reqPageNum;
            timerStart     <= 1'b1;
            timerCount     <= 32'(ERASE_CYCLES);
          end
          else if (reqWrite)
          begin
            op          <= OP_WRITE;
            flashWr     <= 1'b1;
            flashAddr   <= reqAddr;
            flashWrData <= reqData;
            timerStart  <= 1'b1;
            timerCount  <= 32'(WRITE_CYCLES);
          end
        end
        OP_WRITE, OP_PAGE, OP_MASS:
        begin
          if (timerDone)
            op <= OP_IDLE;
        end
        default:
          op <= OP_IDLE;
      endcase
    end
  end

  flash_timer u_timer
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (timerStart),
    .count (timerCount),
    .busy  (timerBusy),
    .done  (timerDone)
  );

  assign flashBusy = (op != OP_IDLE) || timerStart || timerBusy;

  // Data RAM path for stores with write enable clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      xramWr   <= 1'b0;
      xramAddr <= 16'h0000;
      xramData <= RESET_BYTE;
    end
    else
    begin
      xramWr <= xStore && !writeEnable;
      if (xStore && !writeEnable)
      begin
        xramAddr <= xAddr;
        xramData <= xData;
      end
    end
  end

  // Control register bits
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      writeEnable     <= 1'b0;
      massEraseEnable <= 1'b0;
      securityEnable  <= 1'b0;
      erasePageNumber <= 6'h00;
      upperBankSelect <= RESET_BANK;
    end
    else
    begin
      if (ctrlWr && !irqGlobalEnable)
        writeEnable <= sfrWrData[PWE_BIT];
      if (ctrlWr)
        massEraseEnable <= sfrWrData[MEEN_BIT];
      else if (op == OP_IDLE && reqMass)
        massEraseEnable <= 1'b0;
      if (ctrlWr && sfrWrData[SECURITY_ENABLE_BIT])
        securityEnable <= 1'b1;
      if (sfrWr && sfrAddr == SFR_PAGE_ADDR)
        erasePageNumber <= sfrWrData[PAGE_MSB:PAGE_LSB];
      if (bankSelWr)
        upperBankSelect <= bankSelData;
    end
  end

  // Interrupt events
  assign idleEvt = engineBusyLast && !engineBusy;
  assign skipEvt = enginePassDue && (op != OP_IDLE);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      engineBusyLast        <= 1'b0;
      engineIdleIrq         <= 1'b0;
      writeCollisionDropIrq <= 1'b0;
      writeCollisionSkipIrq <= 1'b0;
      enginePassSkip        <= 1'b0;
    end
    else
    begin
      engineBusyLast        <= engineBusy;
      engineIdleIrq         <= idleEvt;
      writeCollisionDropIrq <= dropEvt;
      writeCollisionSkipIrq <= skipEvt && op == OP_WRITE;
      enginePassSkip        <= skipEvt;
    end
  end

  // Sticky flags; writing zero clears, a new event wins
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      idleFlag <= 1'b0;
      dropFlag <= 1'b0;
      skipFlag <= 1'b0;
    end
    else
    begin
      if (idleEvt)
        idleFlag <= 1'b1;
      else if (irqRegWr && !sfrWrData[IDLE_IRQ_BIT])
        idleFlag <= 1'b0;
      if (dropEvt)
        dropFlag <= 1'b1;
      else if (irqRegWr && !sfrWrData[DROP_IRQ_BIT])
        dropFlag <= 1'b0;
      if (skipEvt && op == OP_WRITE)
        skipFlag <= 1'b1;
      else if (irqRegWr && !sfrWrData[SKIP_IRQ_BIT])
        skipFlag <= 1'b0;
    end
  end

  // Register read port
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      sfrRdData <= RESET_BYTE;
    else if (sfrRd)
    begin
      sfrRdData <= RESET_BYTE;
      case (sfrAddr)
        SFR_FLASH_CTRL:
        begin
          sfrRdData[PWE_BIT]      <= writeEnable;
          sfrRdData[MEEN_BIT]     <= massEraseEnable;
          sfrRdData[STATUS_A_BIT] <= statusA;
          sfrRdData[SECURITY_ENABLE_BIT]   <= securityEnable;
        end
        SFR_PAGE_ADDR:
          sfrRdData[PAGE_MSB:PAGE_LSB] <= erasePageNumber;
        SFR_IRQ_REQUEST:
        begin
          sfrRdData[IDLE_IRQ_BIT] <= idleFlag;
          sfrRdData[DROP_IRQ_BIT] <= dropFlag;
          sfrRdData[SKIP_IRQ_BIT] <= skipFlag;
        end
        default:
          sfrRdData <= RESET_BYTE;
      endcase
    end
  end

  // Fetch mapping and read data
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      progFlashAddr   <= '0;
      engineFetchAddr <= '0;
      progRdData      <= ERASED_BYTE;
    end
    else
    begin
      progFlashAddr   <= mapAddr(progAddr, upperBankSelect);
      engineFetchAddr <= FLASH_AW'({engineCodeLocation, 10'h000})
                       + FLASH_AW'({engineFetchWord, 1'b0});
      if (op == OP_MASS || (op == OP_PAGE
          && progFlashAddr[FLASH_AW-1:PAGE_SHIFT] == 8'(erasingPage)))
        progRdData <= ERASED_BYTE;
      else
        progRdData <= flashRdData;
    end
  end

endmodule

/* dv/flash_write_erase_bank_security_props.sv */
// Port checker for the flash controller.
// Bound to the top module; single mclk domain.
module flash_write_erase_bank_security_props
  import flash_ctl_pkg::*;
(
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic [7:0]          sfrWrData,
  input wire logic                sfrWr,
  input wire logic                xStore,
  input wire logic [15:0]         xAddr,
  input wire logic                xramWr,
  input wire logic [15:0]         xramAddr,
  input wire logic                engineBusy,
  input wire logic                engineIdleIrq,
  input wire logic                enginePassDue,
  input wire logic                enginePassSkip,
  input wire logic                writeCollisionDropIrq,
  input wire logic                iceWrite,
  input wire logic                icePageErase,
  input wire logic                flashWr,
  input wire logic                flashPageErase,
  input wire logic [FLASH_AW-1:0] flashAddr,
  input wire logic                flashBusy,
  input wire logic                statusA,
  input wire logic                iceGrant,
  input wire logic [15:0]         progAddr,
  input wire logic [FLASH_AW-1:0] progFlashAddr,
  input wire logic [2:0]          upperBankSelect,
  input wire logic [7:0]          engineCodeLocation,
  input wire logic [11:0]         engineFetchWord,
  input wire logic [FLASH_AW-1:0] engineFetchAddr
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic [6:0] bootCnt;

  // Cycles since reset release, saturating
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      bootCnt <= 7'd0;
    else if (bootCnt < 7'd64)
      bootCnt <= bootCnt + 7'd1;
  end

  AST_IDLE_IRQ: assert property ($fell(engineBusy) |=> engineIdleIrq)
    else $error("idle irq missing");
  AST_DROP_CAUSE: assert property (writeCollisionDropIrq |->
    $past(engineBusy) && ($past(xStore) || $past(iceWrite)))
    else $error("drop irq without cause");
  AST_NO_WR_BUSY: assert property (flashWr |-> !$past(engineBusy))
    else $error("flash write while engine busy");
  AST_SKIP: assert property (enginePassDue && flashBusy |=> enginePassSkip)
    else $error("pass not skipped");
  AST_XRAM: assert property (xramWr |-> $past(xStore) && xramAddr == $past(xAddr))
    else $error("bad ram store");
  AST_STATUS_A: assert property (statusA == (bootCnt < 7'd60))
    else $error("status_a window wrong");
  AST_ICE_INHIBIT: assert property (iceGrant |-> !statusA)
    else $error("ice granted in status_a");
  AST_BANK: assert property (1'b1 |=> progFlashAddr ==
    {($past(progAddr[15]) ? $past(upperBankSelect) : 3'h0), $past(progAddr[14:0])})
    else $error("bank map wrong");
  AST_FETCH: assert property (1'b1 |=> engineFetchAddr ==
    {$past(engineCodeLocation), 10'h000} + {$past(engineFetchWord), 1'b0})
    else $error("fetch address wrong");
  AST_PAGE_ERASE: assert property (flashPageErase |-> flashAddr[9:0] == 10'h000 &&
    ($past(icePageErase) || ($past(sfrWr) && $past(sfrWrData) == PATTERN_PAGE)))
    else $error("page erase without pattern");

  COV_SKIP: cover property (enginePassSkip);
  COV_DROP: cover property (writeCollisionDropIrq);
  COV_ERASE: cover property (flashPageErase);
endmodule

bind flash_write_erase_bank_security flash_write_erase_bank_security_props
  u_flash_write_erase_bank_security_props (.mclk, .rst_n, .sfrWrData, .sfrWr, .xStore,
  .xAddr, .xramWr, .xramAddr, .engineBusy, .engineIdleIrq, .enginePassDue,
  .enginePassSkip, .writeCollisionDropIrq, .iceWrite, .icePageErase, .flashWr,
  .flashPageErase, .flashAddr, .flashBusy, .statusA, .iceGrant, .progAddr,
  .progFlashAddr, .upperBankSelect, .engineCodeLocation, .engineFetchWord,
  .engineFetchAddr);

/* dv/flash_far_side.sv */
// Far-side model: compute engine passes and the flash array.
// Engine runs 40-cycle passes, busy 12 cycles, only while runEn.
module flash_far_side
  import flash_ctl_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                runEn,
  input  wire logic                enginePassSkip,
  input  wire logic                flashWr,
  input  wire logic                flashPageErase,
  input  wire logic                flashMassErase,
  input  wire logic [FLASH_AW-1:0] flashAddr,
  input  wire logic [7:0]          flashWrData,
  input  wire logic [FLASH_AW-1:0] progFlashAddr,
  output logic                     engineBusy,
  output logic                     enginePassDue,
  output logic [7:0]               flashRdData
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [int];
  int         phase;

  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : ERASED_BYTE;
  endfunction

  always @(posedge mclk)
  begin
    if (!rst_n || !runEn)
    begin
      phase <= 0;
      engineBusy <= 1'b0;
      enginePassDue <= 1'b0;
    end
    else
    begin
      phase <= (phase == 39) ? 0 : phase + 1;
      enginePassDue <= (phase == 0);
      if (phase == 2)
        engineBusy <= !enginePassSkip;
      else if (phase == 14)
        engineBusy <= 1'b0;
    end
  end

  always @(posedge mclk)
  begin
    if (flashMassErase)
      mem.delete();
    else if (flashPageErase)
      for (int a = 0; a < PAGE_BYTES; a++)
        mem.delete(int'(flashAddr) + a);
    else if (flashWr)
      mem[int'(flashAddr)] = flashWrData & rd(int'(flashAddr));
  end

  always @(negedge mclk)
    flashRdData = rd(int'(progFlashAddr));
endmodule

/* dv/tb_flash_write_erase_bank_security.sv */
// Self-checking bench for the flash controller.
// Bench plays processor, SFR port and emulator; far-side model plays engine and array.
module tb_flash_write_erase_bank_security
  import flash_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sfrWr, sfrRd, irqGlobalEnable, bankSelWr, xStore, iceEnable, iceWrite, runEn;
  logic xramWr, engineBusy, enginePassDue, enginePassSkip, engineIdleIrq, flashBusy;
  logic writeCollisionDropIrq, writeCollisionSkipIrq, iceGrant, statusA;
  logic flashWr, flashPageErase, flashMassErase, iceMassErase, icePageErase;
  logic [5:0] icePage;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, engineCodeLocation, flashRdData;
  logic [7:0] progRdData, xData, xramData, flashWrData, d, v;
  logic [2:0] bankSelData, upperBankSelect;
  logic [11:0] engineFetchWord;
  logic [15:0] progAddr, xAddr, xramAddr, a;
  logic [FLASH_AW-1:0] engineFetchAddr, progFlashAddr, flashAddr;
  int error_cnt, n_tests, nWr, nPe, nMe, nDrop, nSkip, nX;
  int seed = 32'h68f4_b8e3;
  logic [7:0] refMem [int];

  always #2.5 mclk = ~mclk;

  flash_write_erase_bank_security #(.WRITE_CYCLES(30), .ERASE_CYCLES(50))
    u_flash_write_erase_bank_security (.mclk, .rst_n, .sfrAddr, .sfrWrData, .sfrWr,
    .sfrRd, .sfrRdData, .irqGlobalEnable, .bankSelWr, .bankSelData, .upperBankSelect,
    .engineCodeLocation, .engineFetchWord, .engineFetchAddr, .progAddr, .progFlashAddr,
    .flashRdData, .progRdData, .xStore, .xAddr, .xData, .xramWr, .xramAddr, .xramData,
    .engineBusy, .enginePassDue, .enginePassSkip, .engineIdleIrq, .writeCollisionDropIrq,
    .writeCollisionSkipIrq, .iceEnable, .iceGrant, .iceMassErase,
    .icePageErase, .icePage, .iceWrite, .iceAddr(18'h0_0000),
    .iceData(8'h00), .flashWr, .flashPageErase, .flashMassErase, .flashAddr,
    .flashWrData, .flashBusy, .statusA);

  flash_far_side u_flash_far_side (.mclk, .rst_n, .runEn, .enginePassSkip, .flashWr,
    .flashPageErase, .flashMassErase, .flashAddr, .flashWrData, .progFlashAddr,
    .engineBusy, .enginePassDue, .flashRdData);

  always @(posedge mclk)
  begin
    nWr += flashWr;
    nPe += flashPageErase;
    nMe += flashMassErase;
    nDrop += writeCollisionDropIrq;
    nSkip += writeCollisionSkipIrq;
    nX += xramWr;
  end

  task automatic test_done;
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_v(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      error_cnt++;
      $display("Error t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] expv(input int k);
    return refMem.exists(k) ? refMem[k] : 8'hFF;
  endfunction

  task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge mclk);
    sfrAddr <= ad;
    sfrWrData <= dt;
    sfrWr <= 1'b1;
    @(posedge mclk);
    sfrWr <= 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] ad, output logic [7:0] dt);
    @(posedge mclk);
    sfrAddr <= ad;
    sfrRd <= 1'b1;
    @(posedge mclk);
    sfrRd <= 1'b0;
    @(posedge mclk);
    dt = sfrRdData;
  endtask

  task automatic store(input logic [15:0] ad, input logic [7:0] dt);
    @(posedge mclk);
    xAddr <= ad;
    xData <= dt;
    xStore <= 1'b1;
    @(posedge mclk);
    xStore <= 1'b0;
  endtask

  task automatic rd_prog(input logic [15:0] ad, output logic [7:0] dt);
    @(posedge mclk);
    progAddr <= ad;
    repeat (3) @(posedge mclk);
    dt = progRdData;
  endtask

  task automatic wait_idle;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 400 && flashBusy !== 1'b0; i++)
      @(posedge mclk);
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    test_done();
  end

  initial
  begin
    {sfrWr, sfrRd, irqGlobalEnable, bankSelWr, xStore, iceWrite, runEn} = '0;
    {iceMassErase, icePageErase, icePage} = '0;
    {sfrAddr, sfrWrData, engineCodeLocation, xData, xAddr, progAddr} = '0;
    {bankSelData, engineFetchWord} = '0;
    iceEnable = 1'b1;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    sfr_rd(SFR_FLASH_CTRL, d);
    chk_v(d[STATUS_A_BIT], 1'b1);
    chk_v(d[SECURITY_ENABLE_BIT], 1'b0);
    chk_v(iceGrant, 1'b0);
    repeat (60) @(posedge mclk);
    sfr_rd(SFR_FLASH_CTRL, d);
    chk_v(d[STATUS_A_BIT], 1'b0);
    chk_v(iceGrant, 1'b1);
    sfr_rd(8'h10, d);
    chk_v(d, 8'h00);
    irqGlobalEnable <= 1'b1;
    sfr_wr(SFR_FLASH_CTRL, 8'h01);
    sfr_rd(SFR_FLASH_CTRL, d);
    chk_v(d[PWE_BIT], 1'b0);
    irqGlobalEnable <= 1'b0;
    $display("boot and enable tests done");
    for (int i = 0; i < 4; i++)
    begin
      a = 16'h0800 + 16'(i * 16) + 16'($random(seed) & 15);
      v = 8'($random(seed));
      sfr_wr(SFR_FLASH_CTRL, 8'h01);
      store(a, v);
      wait_idle();
      sfr_wr(SFR_FLASH_CTRL, 8'h00);
      refMem[a] = v;
      chk_v(flashAddr, {2'b00, a});
      chk_v(flashWrData, v);
      rd_prog(a, d);
      chk_v(d, expv(a));
    end
    store(16'h0123, 8'hA5);
    repeat (2) @(posedge mclk);
    chk_v(xramAddr, 16'h0123);
    chk_v(xramData, 8'hA5);
    chk_n(nX, 1);
    chk_n(nWr, 4);
    $display("write tests done");
    sfr_wr(SFR_FLASH_CTRL, 8'h01);
    runEn <= 1'b1;
    for (int i = 0; i < 100 && engineBusy !== 1'b1; i++)
      @(posedge mclk);
    store(16'h0C80, 8'h11);
    repeat (20) @(posedge mclk);
    chk_n(nDrop, 1);
    chk_n(nWr, 4);
    sfr_rd(SFR_IRQ_REQUEST, d);
    chk_v(d[DROP_IRQ_BIT], 1'b1);
    chk_v(d[IDLE_IRQ_BIT], 1'b1);
    sfr_wr(SFR_IRQ_REQUEST, 8'h00);
    sfr_rd(SFR_IRQ_REQUEST, d);
    chk_v(d[DROP_IRQ_BIT], 1'b0);
    for (int i = 0; i < 100 && engineIdleIrq !== 1'b1; i++)
      @(posedge mclk);
    store(16'h0C90, 8'h3C);
    wait_idle();
    refMem[16'h0C90] = 8'h3C;
    chk_n(nSkip, 1);
    sfr_rd(SFR_IRQ_REQUEST, d);
    chk_v(d[SKIP_IRQ_BIT], 1'b1);
    rd_prog(16'h0C90, d);
    chk_v(d, expv(16'h0C90));
    runEn <= 1'b0;
    $display("collision tests done");
    sfr_wr(SFR_PAGE_ADDR, 8'h0C);
    sfr_wr(SFR_ERASE_PATTERN, PATTERN_PAGE);
    wait_idle();
    for (int k = 16'h0C00; k < 16'h1000; k++)
      refMem.delete(k);
    chk_n(nPe, 1);
    chk_v(flashAddr, 18'h0_0C00);
    rd_prog(16'h0C90, d);
    chk_v(d, expv(16'h0C90));
    rd_prog(a, d);
    chk_v(d, expv(a));
    for (int b = 0; b < 8; b++)
    begin
      @(posedge mclk);
      bankSelData <= 3'(b);
      bankSelWr <= 1'b1;
      engineCodeLocation <= 8'($random(seed));
      engineFetchWord <= 12'($random(seed));
      @(posedge mclk);
      bankSelWr <= 1'b0;
      progAddr <= 16'h8000 | 16'($random(seed));
      repeat (2) @(posedge mclk);
      chk_v(progFlashAddr, {3'(b), progAddr[14:0]});
    end
    $display("erase and bank tests done");
    iceEnable <= 1'b0;
    sfr_wr(SFR_FLASH_CTRL, 8'h02);
    sfr_wr(SFR_ERASE_PATTERN, PATTERN_MASS);
    repeat (4) @(posedge mclk);
    chk_n(nMe, 0);
    iceEnable <= 1'b1;
    sfr_wr(SFR_FLASH_CTRL, 8'h40);
    sfr_wr(SFR_FLASH_CTRL, 8'h00);
    sfr_rd(SFR_FLASH_CTRL, d);
    chk_v(d[SECURITY_ENABLE_BIT], 1'b1);
    chk_v(iceGrant, 1'b0);
    {iceWrite, icePageErase} <= 2'b11;
    @(posedge mclk);
    {iceWrite, icePageErase} <= 2'b00;
    sfr_wr(SFR_PAGE_ADDR, 8'h00);
    sfr_wr(SFR_ERASE_PATTERN, PATTERN_PAGE);
    sfr_wr(SFR_FLASH_CTRL, 8'h01);
    store(16'h0010, 8'h00);
    repeat (4) @(posedge mclk);
    chk_n(nPe, 1);
    chk_n(nWr, 5);
    sfr_wr(SFR_FLASH_CTRL, 8'h02);
    sfr_wr(SFR_ERASE_PATTERN, PATTERN_MASS);
    wait_idle();
    refMem.delete();
    chk_n(nMe, 1);
    rd_prog(a, d);
    chk_v(d, 8'hFF);
    iceMassErase <= 1'b1;
    @(posedge mclk);
    iceMassErase <= 1'b0;
    wait_idle();
    chk_n(nMe, 2);
    sfr_rd(SFR_FLASH_CTRL, d);
    chk_v(d[SECURITY_ENABLE_BIT], 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    sfr_rd(SFR_FLASH_CTRL, d);
    chk_v(d[SECURITY_ENABLE_BIT], 1'b0);
    $display("security tests done");
    test_done();
  end
endmodule
